//--- serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input  wire logic so,
  output logic      csbN,
  output logic      sclk,
  output logic      si
);
  // Half link period; a larger value plays a slow host
  int halfNs = 16;
  initial begin
    csbN = 1'b1;
    sclk = 1'b0;
    si   = 1'b1;
  end
  // ****************************************
  // Frame: bytes MSB first from tx[23]
  // ****************************************
  task automatic frame(input logic [23:0] tx, input int nBytes, output logic [7:0] rx);
    rx = 8'h00;
    // Keep pin changes off the core sampling edge
    #1;
    csbN = 1'b0;
    #(2*halfNs);
    for (int i = 0; i < 8*nBytes; i++) begin
      si = tx[23-i];
      #(halfNs) sclk = 1'b1;
      rx = {rx[6:0], so};
      #(halfNs) sclk = 1'b0;
    end
    #(2*halfNs) csbN = 1'b1;
    // Released line never keeps a stale level
    si = ~si;
    #(4*halfNs - 1);
  endtask
endmodule // serial_host_model
`default_nettype wire

//--- speech_cmd_pkg.sv
`default_nettype none
package speech_cmd_pkg;
  localparam int BYTE_W   = 8;
  localparam int CHAN_N   = 4;
  localparam int PHRASE_W = 12;
  localparam int FLAG_N   = 8;
  localparam int ADDR_W   = 5;
  localparam int DATA_W   = 32;

  // ****************************************
  // Serial opcodes
  // ****************************************
  localparam logic [7:0] OP_ROM_INFO    = 8'hb4;
  localparam logic [6:0] OP_FAULT_READ  = 7'h5c;  // Low bit is the selector
  localparam logic [7:0] OP_STATUS_SEL  = 8'hc0;
  localparam logic [7:0] OP_WIDE_PRESET = 8'hc4;
  localparam logic [7:0] OP_WIDE_PLAY   = 8'hc8;
  localparam logic [7:0] OP_FAULT_CLEAR = 8'hff;

  // ****************************************
  // Fault byte layout
  // ****************************************
  localparam int FLG_CMD   = 0;
  localparam int FLG_OPEN  = 1;
  localparam int FLG_TEMP  = 2;
  localparam int FLG_SHORT = 3;
  localparam int FLG_FLASH = 4;
  localparam int FLG_WDT   = 5;
  localparam int FLG_RSTC  = 6;
  localparam int FLG_OSC   = 7;

  // ****************************************
  // Argument byte fields
  // ****************************************
  localparam int ARG_TOP    = 7;
  localparam int ARG_PORT   = 6;
  localparam int ARG_CH_LSB = 4;
  localparam logic [1:0] SRC_PLAYING = 2'h0;
  localparam logic [1:0] SRC_ACCEPT  = 2'h1;
  localparam logic [1:0] WDT_NONE    = 2'h0;
  localparam logic [1:0] WDT_ONCE    = 2'h1;
  localparam logic [1:0] WDT_TWICE   = 2'h2;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_CTRL    = 5'h00;
  localparam logic [ADDR_W-1:0] REG_FAULT   = 5'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 5'h08;
  localparam logic [ADDR_W-1:0] REG_PHRASE0 = 5'h10;
  localparam int CTRL_ROM_LSB  = 8;
  localparam int STAT_PLAY_LSB = 4;
  localparam int STAT_SELA_LSB = 8;
  localparam int STAT_SELB_LSB = 16;
  localparam logic [7:0] FAULT_EN_RST = 8'hff;
  localparam logic [7:0] ROM_INFO_RST = 8'h00;

  typedef enum logic [1:0] {
    ST_OPCODE   = 2'b00,
    ST_ARG1     = 2'b01,
    ST_ARG2     = 2'b10,
    ST_READBACK = 2'b11
  } dec_state_t;

  typedef struct packed {
    logic [1:0] source;
    logic [3:0] mask;
  } status_sel_t;

  localparam status_sel_t SEL_A_RST = '{source: SRC_ACCEPT, mask: 4'h1};
  localparam status_sel_t SEL_B_RST = '{source: SRC_PLAYING, mask: 4'h1};

  typedef struct packed {
    logic                valid;
    logic [1:0]          chan;
    logic [PHRASE_W-1:0] phrase;
  } phrase_evt_t;

  typedef struct packed {
    logic [CHAN_N-1:0] processing;
    logic [CHAN_N-1:0] waiting;
    logic [CHAN_N-1:0] sounding;
  } chan_state_t;

  typedef struct packed {
    logic oscStop;
    logic flashErr;
    logic spkShort;
    logic overTemp;
    logic spkOpen;
    logic wdtOverflow;
    logic rstCntOverflow;
  } fault_in_t;

  typedef struct packed {
    logic [1:0]                       csbSync;
    logic [1:0]                       sclkSync;
    logic [1:0]                       siSync;
    logic                             sclkPrev;
    dec_state_t                       dec;
    logic [2:0]                       bitCnt;
    logic [6:0]                       rxShift;
    logic [7:0]                       cmd;
    logic [5:0]                       hold;
    logic [7:0]                       txShift;
    logic                             serialOut;
    status_sel_t                      selA;
    status_sel_t                      selB;
    logic                             statusA;
    logic                             statusB;
    logic [CHAN_N-1:0]                accN;
    logic [CHAN_N-1:0]                playN;
    logic [FLAG_N-1:0]                flags;
    logic [FLAG_N-1:0]                faultEn;
    logic [7:0]                       romInfo;
    logic [1:0]                       wdtCnt;
    logic [CHAN_N-1:0][PHRASE_W-1:0]  phrase;
    phrase_evt_t                      preset;
    phrase_evt_t                      play;
    logic                             waitReq;
    logic [DATA_W-1:0]                rdData;
  } dec_regs_t;
endpackage
`default_nettype wire

//--- status_fault_phrase_cmd_decoder.sv
// Overview of operation
// - ROM-information read returns the 8-bit info value MSB first in the next byte.
// - Info read, fault read and status select work regardless of channel state.
// - Fault read opcode has a selector bit; eight flags follow in the next byte.
// - Fault byte: osc, reset counter, watchdog, flash, short, temp, open, command.
// - Malformed or illegal command sequences set the command-error flag.
// - Speaker-open detector sets the speaker-open flag.
// - Over-temperature sensor sets the over-temperature flag.
// - Speaker short detector sets the speaker-short flag.
// - Flash access error sets the flash-error flag.
// - First watchdog overflow sets the watchdog flag.
// - Second watchdog overflow or reset-counter overflow sets the reset-counter flag.
// - Oscillator stop sets the oscillator-stop flag.
// - Status select is two bytes; bit 7 zero, bit 6 picks pin A or B.
// - Each status pin keeps its own selection.
// - Reset: pin A shows channel 0 accept, pin B channel 0 playing.
// - Source 00 playing, 01 accept, 1x combined fault.
// - Channel mask applies to playing and accept; several channels allowed.
// - Wide preset: opcode, 00+channel+phrase high nibble, phrase low byte; stores phrase.
// - Preset alone never starts playback.
// - Channel index 0..3 maps to channels 0..3.
// - Wide play uses the same layout and starts the phrase directly.
// - Accept signal low while processing or waiting to play, else high.
// - Playing signal low while processing or sounding, else high.
// - Fault clear resets flags; flags of faults still present stay set.
`timescale 1ns/1ps
`default_nettype none
module status_fault_phrase_cmd_decoder (
  input  wire  logic                             core_clk,
  input  wire  logic                             rst_n,
  input  wire  logic                             csbN,
  input  wire  logic                             sclk,
  input  wire  logic                             si,
  output logic                                   so,
  output logic                                   statusOutA,
  output logic                                   statusOutB,
  input  wire  speech_cmd_pkg::chan_state_t      chanState,
  input  wire  speech_cmd_pkg::fault_in_t        faultIn,
  output logic [speech_cmd_pkg::CHAN_N-1:0]      cmdAcceptN,
  output logic [speech_cmd_pkg::CHAN_N-1:0]      playingN,
  output speech_cmd_pkg::phrase_evt_t            presetEvt,
  output speech_cmd_pkg::phrase_evt_t            playEvt,
  input  wire  logic [speech_cmd_pkg::ADDR_W-1:0] avs_address,
  input  wire  logic                             avs_read,
  input  wire  logic                             avs_write,
  input  wire  logic [speech_cmd_pkg::DATA_W-1:0] avs_writedata,
  output logic [speech_cmd_pkg::DATA_W-1:0]      avs_readdata,
  output logic                                   avs_waitrequest
);
  import speech_cmd_pkg::*;

  dec_regs_t st;
  dec_regs_t next_st;

  function automatic logic pinValue(status_sel_t s, logic [CHAN_N-1:0] accN, logic [CHAN_N-1:0] playN,
                                    logic fault);
    logic v;
    v = fault;
    if (s.source == SRC_PLAYING) begin
      v = &(playN | ~s.mask);
    end else if (s.source == SRC_ACCEPT) begin
      v = &(accN | ~s.mask);
    end
    return v;
  endfunction

  function automatic logic isReg(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] r);
    return a[ADDR_W-1:2] == r[ADDR_W-1:2];
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  logic              sclkRise;
  logic              sclkFall;
  logic              byteDone;
  logic [7:0]        rxByte;
  logic [FLAG_N-1:0] setFlags;
  logic [FLAG_N-1:0] clrMask;
  logic              cmdErr;
  logic              busDo;
  logic [1:0]        chanIdx;

  always_comb begin
    next_st = st;
    setFlags = '0;
    clrMask = '0;
    cmdErr = 1'b0;
    chanIdx = st.hold[ARG_CH_LSB +: 2];
    // Pin inputs pass two flops; only the second is read
    next_st.csbSync = {st.csbSync[0], csbN};
    next_st.sclkSync = {st.sclkSync[0], sclk};
    next_st.siSync = {st.siSync[0], si};
    next_st.sclkPrev = st.sclkSync[1];
    sclkRise = st.sclkSync[1] & ~st.sclkPrev;
    sclkFall = ~st.sclkSync[1] & st.sclkPrev;
    rxByte = {st.rxShift, st.siSync[1]};
    byteDone = 1'b0;
    next_st.preset.valid = 1'b0;
    next_st.play.valid = 1'b0;

    if (st.csbSync[1]) begin
      // Frame end mid-command counts as malformed
      if (st.bitCnt != '0 || st.dec != ST_OPCODE) begin
        cmdErr = 1'b1;
      end
      next_st.dec = ST_OPCODE;
      next_st.bitCnt = '0;
      next_st.serialOut = 1'b0;
    end else begin
      if (sclkRise) begin
        next_st.rxShift = rxByte[6:0];
        next_st.bitCnt = st.bitCnt + 3'h1;
        byteDone = &st.bitCnt;
      end
      if (sclkFall && st.dec == ST_READBACK) begin
        next_st.serialOut = st.txShift[7];
        next_st.txShift = {st.txShift[6:0], 1'b0};
      end
    end

    if (byteDone) begin
      unique case (st.dec)
        ST_OPCODE: begin
          next_st.cmd = rxByte;
          // No channel-state gating on these opcodes
          if (rxByte == OP_ROM_INFO) begin
            next_st.txShift = st.romInfo;
            next_st.dec = ST_READBACK;
          end else if (rxByte[7:1] == OP_FAULT_READ) begin
            next_st.txShift = st.flags;
            next_st.dec = ST_READBACK;
          end else if (rxByte == OP_STATUS_SEL || rxByte == OP_WIDE_PRESET || rxByte == OP_WIDE_PLAY) begin
            next_st.dec = ST_ARG1;
          end else if (rxByte == OP_FAULT_CLEAR) begin
            clrMask = '1;
          end
        end
        ST_ARG1: begin
          next_st.dec = ST_OPCODE;
          if (rxByte[ARG_TOP] || (st.cmd != OP_STATUS_SEL && rxByte[ARG_PORT])) begin
            cmdErr = 1'b1;
          end else if (st.cmd == OP_STATUS_SEL) begin
            // Only the addressed pin changes
            if (rxByte[ARG_PORT]) begin
              next_st.selB = rxByte[5:0];
            end else begin
              next_st.selA = rxByte[5:0];
            end
          end else begin
            next_st.hold = rxByte[5:0];
            next_st.dec = ST_ARG2;
          end
        end
        ST_ARG2: begin
          next_st.dec = ST_OPCODE;
          if (!st.accN[chanIdx]) begin
            // Host broke the accept handshake: channel not accepting
            cmdErr = 1'b1;
          end else begin
            next_st.phrase[chanIdx] = {st.hold[3:0], rxByte};
            if (st.cmd == OP_WIDE_PLAY) begin
              next_st.play = '{valid: 1'b1, chan: chanIdx, phrase: {st.hold[3:0], rxByte}};
            end else begin
              next_st.preset = '{valid: 1'b1, chan: chanIdx, phrase: {st.hold[3:0], rxByte}};
            end
          end
        end
        ST_READBACK: begin
          next_st.dec = ST_OPCODE;
          if (rxByte != '0) begin
            cmdErr = 1'b1;
          end
        end
      endcase
    end

    // ****************************************
    // Fault flags
    // ****************************************
    setFlags[FLG_CMD] = cmdErr;
    setFlags[FLG_OPEN] = faultIn.spkOpen;
    setFlags[FLG_TEMP] = faultIn.overTemp;
    setFlags[FLG_SHORT] = faultIn.spkShort;
    setFlags[FLG_FLASH] = faultIn.flashErr;
    setFlags[FLG_WDT] = faultIn.wdtOverflow && st.wdtCnt == WDT_NONE;
    setFlags[FLG_RSTC] = faultIn.rstCntOverflow || (faultIn.wdtOverflow && st.wdtCnt != WDT_NONE);
    setFlags[FLG_OSC] = faultIn.oscStop;
    setFlags = setFlags & st.faultEn;
    if (faultIn.wdtOverflow && st.wdtCnt != WDT_TWICE) begin
      next_st.wdtCnt = st.wdtCnt + WDT_ONCE;
    end

    // ****************************************
    // Register bus, one wait state
    // ****************************************
    busDo = (avs_read || avs_write) && !st.waitReq;
    next_st.waitReq = !((avs_read || avs_write) && st.waitReq);
    next_st.rdData = '0;
    if ((avs_read || avs_write) && st.waitReq) begin
      if (isReg(avs_address, REG_CTRL)) begin
        next_st.rdData = {16'h0, st.romInfo, st.faultEn};
      end else if (isReg(avs_address, REG_FAULT)) begin
        next_st.rdData = {24'h0, st.flags};
      end else if (isReg(avs_address, REG_STATUS)) begin
        next_st.rdData = {10'h0, st.selB, 2'h0, st.selA, st.playN, st.accN};
      end else if (avs_address[ADDR_W-1]) begin
        next_st.rdData = {20'h0, st.phrase[avs_address[3:2]]};
      end
    end
    if (busDo && avs_write) begin
      if (isReg(avs_address, REG_CTRL)) begin
        next_st.faultEn = avs_writedata[FLAG_N-1:0];
        next_st.romInfo = avs_writedata[CTRL_ROM_LSB +: 8];
      end else if (isReg(avs_address, REG_FAULT)) begin
        clrMask = clrMask | avs_writedata[FLAG_N-1:0];
      end
    end
    if (clrMask[FLG_WDT] || clrMask[FLG_RSTC]) begin
      next_st.wdtCnt = WDT_NONE;
    end
    // Set beats clear so a still-present fault survives
    next_st.flags = (st.flags & ~clrMask) | setFlags;

    // ****************************************
    // Channel status and pins
    // ****************************************
    next_st.accN = ~(chanState.processing | chanState.waiting);
    next_st.playN = ~(chanState.processing | chanState.sounding);
    next_st.statusA = pinValue(st.selA, st.accN, st.playN, |st.flags);
    next_st.statusB = pinValue(st.selB, st.accN, st.playN, |st.flags);
  end

  localparam dec_regs_t STATE_RST = '{
    csbSync: 2'h3, sclkSync: 2'h0, siSync: 2'h0, sclkPrev: 1'b0, dec: ST_OPCODE, bitCnt: 3'h0,
    rxShift: 7'h0, cmd: 8'h0, hold: 6'h0, txShift: 8'h0, serialOut: 1'b0,
    selA: SEL_A_RST, selB: SEL_B_RST, statusA: 1'b1, statusB: 1'b1,
    accN: 4'hf, playN: 4'hf, flags: 8'h0, faultEn: FAULT_EN_RST, romInfo: ROM_INFO_RST,
    wdtCnt: WDT_NONE, phrase: '0, preset: '0, play: '0, waitReq: 1'b1, rdData: '0};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign so = st.serialOut;
  assign statusOutA = st.statusA;
  assign statusOutB = st.statusB;
  assign cmdAcceptN = st.accN;
  assign playingN = st.playN;
  assign presetEvt = st.preset;
  assign playEvt = st.play;
  assign avs_readdata = st.rdData;
  assign avs_waitrequest = st.waitReq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_ROM_LOAD: assert property (byteDone && st.dec == ST_OPCODE && rxByte == OP_ROM_INFO
    |=> st.txShift == $past(st.romInfo) && st.dec == ST_READBACK)
    else $error("rom info not loaded");
  AST_FAULT_LOAD: assert property (byteDone && st.dec == ST_OPCODE && rxByte[7:1] == OP_FAULT_READ
    |=> st.txShift == $past(st.flags))
    else $error("fault byte not loaded");
  AST_OUT_SHIFT: assert property (st.dec == ST_READBACK && !st.csbSync[1] && sclkFall
    |=> so == $past(st.txShift[7]))
    else $error("serial out bit wrong");
  AST_ACCEPT_N: assert property (##1 cmdAcceptN == ~$past(chanState.processing | chanState.waiting))
    else $error("accept signal wrong");
  AST_PLAYING_N: assert property (##1 playingN == ~$past(chanState.processing | chanState.sounding))
    else $error("playing signal wrong");
  AST_TEMP_SET: assert property (faultIn.overTemp && st.faultEn[FLG_TEMP] |=> st.flags[FLG_TEMP])
    else $error("temp flag not set");
  AST_CLEAR_KEEP: assert property (st.flags[FLG_OPEN] && !faultIn.spkOpen && clrMask[FLG_OPEN]
    ##1 !faultIn.spkOpen |=> !st.flags[FLG_OPEN] || $past(faultIn.spkOpen))
    else $error("flag clear lost");
  AST_STICKY: assert property (st.flags[FLG_SHORT] && !clrMask[FLG_SHORT] |=> st.flags[FLG_SHORT])
    else $error("flag not sticky");
  AST_WDT_FIRST: assert property (faultIn.wdtOverflow && st.wdtCnt == WDT_NONE && st.faultEn[FLG_WDT]
    |=> st.flags[FLG_WDT])
    else $error("watchdog flag missing");
  AST_PRESET_ONLY: assert property (presetEvt.valid |-> !playEvt.valid ##1 !playEvt.valid)
    else $error("preset started playback");
  AST_PHRASE_KEEP: assert property (presetEvt.valid |-> st.phrase[presetEvt.chan] == presetEvt.phrase)
    else $error("phrase not stored");
  AST_PIN_A: assert property (##1 statusOutA == pinValue($past(st.selA), $past(st.accN), $past(st.playN),
    |$past(st.flags)))
    else $error("status pin a wrong");
  AST_BUS_ACK: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  CV_ROM_READ: cover property (byteDone && st.dec == ST_OPCODE && rxByte == OP_ROM_INFO);
  CV_FAULT_READ: cover property (byteDone && st.dec == ST_READBACK && st.cmd[7:1] == OP_FAULT_READ);
  CV_PRESET: cover property (presetEvt.valid);
  CV_PLAY: cover property (playEvt.valid);
endmodule  // status_fault_phrase_cmd_decoder
`default_nettype wire

//--- status_fault_phrase_cmd_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module status_fault_phrase_cmd_decoder_test;
  import speech_cmd_pkg::*;
  logic core_clk, rstN, csbN, sclk, si, so, statusOutA, statusOutB;
  logic avRead, avWrite, avWait;
  logic [ADDR_W-1:0] avAddress;
  logic [DATA_W-1:0] avWdata, avRdata, rd;
  logic [CHAN_N-1:0] cmdAcceptN, playingN;
  chan_state_t       chanState;
  fault_in_t         faultIn;
  phrase_evt_t       presetEvt, playEvt, lastPreset, lastPlay;
  logic [7:0]        rx;
  logic [11:0]       ph;
  int failures, nChecks, nPlay;
  int flagOf[7] = '{6, 5, 1, 2, 3, 4, 7};

  status_fault_phrase_cmd_decoder i_dut (.core_clk(core_clk), .rst_n(rstN), .csbN(csbN), .sclk(sclk), .si(si),
    .so(so), .statusOutA(statusOutA), .statusOutB(statusOutB), .chanState(chanState), .faultIn(faultIn),
    .cmdAcceptN(cmdAcceptN), .playingN(playingN), .presetEvt(presetEvt), .playEvt(playEvt),
    .avs_address(avAddress), .avs_read(avRead), .avs_write(avWrite), .avs_writedata(avWdata),
    .avs_readdata(avRdata), .avs_waitrequest(avWait));
  serial_host_model i_host (.so(so), .csbN(csbN), .sclk(sclk), .si(si));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (presetEvt.valid === 1'b1) lastPreset <= presetEvt;
    if (playEvt.valid === 1'b1) begin
      lastPlay <= playEvt;
      nPlay <= nPlay + 1;
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Loops until avWait drops; only the watchdog ends a hung wait
  task automatic busCycle(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    avAddress <= a;
    avWdata <= d;
    avWrite <= wr;
    avRead <= ~wr;
    do @(posedge core_clk); while (avWait !== 1'b0);
    rd = avRdata;
    avWrite <= 1'b0;
    avRead <= 1'b0;
  endtask
  task automatic faultRead(input logic sel);
    i_host.frame({OP_FAULT_READ, sel, 16'h0000}, 2, rx);
    if (rx === 8'h00 && statusOutB === 1'b1) i_host.frame({OP_FAULT_READ, sel, 16'h0000}, 2, rx);
  endtask
  task automatic settle(input chan_state_t cs);
    @(posedge core_clk);
    chanState <= cs;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    results();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rstN = 1'b0; chanState = '0; faultIn = '0; avRead = 1'b0; avWrite = 1'b0; avAddress = '0; avWdata = '0; nPlay = 0;
    repeat (20) @(posedge core_clk);
    rstN <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({statusOutA, statusOutB}, 2'b11, "pins after reset");
    busCycle(1'b0, REG_STATUS, '0);
    check({rd[21:16], rd[13:8]}, 12'h051, "reset selections");
    busCycle(1'b0, 5'h0c, '0);
    check(rd, 32'h0, "unmapped read");
    busCycle(1'b1, REG_CTRL, 32'h0000_a5ff);
    settle('{processing: 4'hf, waiting: 4'h0, sounding: 4'h0});
    check({cmdAcceptN, playingN}, 8'h00, "busy channels");
    i_host.frame({OP_ROM_INFO, 16'h0000}, 2, rx);
    check(rx, 8'ha5, "rom info while busy");
    settle('{processing: 4'h0, waiting: 4'h8, sounding: 4'h2});
    check({cmdAcceptN, playingN}, 8'h7d, "wait and sound");
    i_host.frame({OP_STATUS_SEL, 8'h60, 8'h00}, 2, rx);
    i_host.frame({OP_STATUS_SEL, 8'h03, 8'h00}, 2, rx);
    settle('{processing: 4'h0, waiting: 4'h0, sounding: 4'h2});
    check({statusOutA, statusOutB}, 2'b00, "masked playing");
    settle('{processing: 4'h0, waiting: 4'h0, sounding: 4'h4});
    check(statusOutA, 1'b1, "unmasked channel");
    i_host.frame({OP_STATUS_SEL, 8'h1c, 8'h00}, 2, rx);
    settle('{processing: 4'h0, waiting: 4'h8, sounding: 4'h0});
    check(statusOutA, 1'b0, "accept source");
    busCycle(1'b0, REG_STATUS, '0);
    check({rd[21:16], rd[13:8]}, 12'h81c, "selections kept");
    settle('0);
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk);
      faultIn <= 7'(1 << i);
      @(posedge core_clk);
      faultIn <= '0;
      faultRead(i[0]);
      check(rx, 32'(1 << flagOf[i]), "fault flag");
      busCycle(1'b1, REG_FAULT, 32'hff);
    end
    // Two watchdog pulses: first sets the watchdog flag, second the reset-counter flag
    @(posedge core_clk);
    faultIn <= 7'h02;
    @(posedge core_clk);
    faultIn <= 7'h00;
    @(posedge core_clk);
    faultIn <= 7'h02;
    @(posedge core_clk);
    faultIn <= 7'h08;
    faultRead(1'b0);
    check(rx, 8'h64, "second watchdog");
    check(statusOutB, 1'b1, "fault pin");
    i_host.frame({OP_FAULT_CLEAR, 16'h0000}, 1, rx);
    faultRead(1'b1);
    check(rx, 8'h04, "held fault survives clear");
    @(posedge core_clk);
    faultIn <= '0;
    i_host.frame({OP_FAULT_CLEAR, 16'h0000}, 1, rx);
    i_host.frame({OP_STATUS_SEL, 8'h80, 8'h00}, 2, rx);
    faultRead(1'b0);
    check(rx, 8'h01, "illegal argument");
    busCycle(1'b1, REG_FAULT, 32'hff);
    settle('{processing: 4'h2, waiting: 4'h0, sounding: 4'h0});
    i_host.frame({OP_WIDE_PRESET, 4'h1, 12'h123}, 3, rx);
    faultRead(1'b0);
    check(rx, 8'h01, "phrase while busy");
    check(nPlay, 0, "no event while busy");
    busCycle(1'b1, REG_FAULT, 32'hff);
    settle('0);
    for (int ch = 0; ch < CHAN_N; ch++) begin
      ph = 12'h9c3 + 12'(ch * 273);
      i_host.frame({OP_WIDE_PRESET, 2'b00, 2'(ch), ph}, 3, rx);
      check(lastPreset, {1'b1, 2'(ch), ph}, "preset event");
      check(nPlay, ch, "no start on preset");
      busCycle(1'b0, ADDR_W'(REG_PHRASE0 + 4 * ch), '0);
      check(rd[11:0], ph, "phrase stored");
      i_host.frame({OP_WIDE_PLAY, 2'b00, 2'(ch), ~ph}, 3, rx);
      check(lastPlay, {1'b1, 2'(ch), ~ph}, "play event");
    end
    results();
  end
endmodule // status_fault_phrase_cmd_decoder_test
`default_nettype wire
